// [rtl/ebc_cfg.svh]
// external bus cycle sequencer: offsets, fields, reset values, timing counts
// assumes inclusion by bare name from the sequencer design file
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH
// avalon register offsets (word index, byte address = 4 * index)
`define EBC_REG_CTRL 4'h0
`define EBC_REG_TIMING0 4'h1
`define EBC_REG_TIMING1 4'h2
`define EBC_REG_ADDR 4'h3
`define EBC_REG_WDATA 4'h4
`define EBC_REG_CMD 4'h5
`define EBC_REG_STATUS 4'h6
`define EBC_REG_RDATA 4'h7
// ctrl fields
`define EBC_CTRL_MUX_BIT 0
`define EBC_CTRL_RDY_EN_BIT 1
`define EBC_CTRL_RDY_POL_BIT 2
`define EBC_CTRL_RDY_ASYNC_BIT 3
`define EBC_CTRL_RESET 32'h0000_0000
// timing config fields per chip select: ab[1:0] ext[3:2] c[5:4] d[6] e[11:7] f[13:12]
`define EBC_TIMING_RESET 14'h0F81
// phase limits in timing steps
`define EBC_AB_MIN 3'h1
`define EBC_E_MIN 6'h01
// read value of unmapped register offsets
`define EBC_UNMAPPED_READ 32'h0000_0000
`endif

// [rtl/ebc_pkg.sv]
// types for the external bus cycle sequencer
// assumes the cfg header sits next to it in rtl/
package ebc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_AB = 3'b001,
    ST_C = 3'b010,
    ST_D = 3'b011,
    ST_E = 3'b100,
    ST_RDY = 3'b101,
    ST_F = 3'b110
  } phase_t;
endpackage

// [rtl/ebc_sync.sv]
// two flip-flop synchroniser for a single level
// assumes d comes from outside the mclk domain
`timescale 1ns/1ps
module ebc_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // level in and synchronised level out
  input wire logic d,
  output logic q
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [rtl/ebc_sequencer.sv]
// external bus cycle sequencer: five phase cycles on a mux or demultiplexed_mode parallel bus
// assumes an avalon-mm master on mclk; ready and read data arrive asynchronously
// Functional notes
// [RULE_01] five phases in order: ab, c, d, e, f
// [RULE_02] phase lengths from per-select timing config
// [RULE_03] c 0-3, d 0-1, e 1-32, f 0-3
// [RULE_04] ab 1-2 steps, plus 0-3 on window change
// [RULE_05] d phase: write setup or mux turnaround
// [RULE_06] hold keeps address and write data driven
// [RULE_07] ready input may stretch access phase
// [RULE_08] read data captured when strobe rises
// [RULE_09] demultiplexed_mode address change cannot corrupt read
// [RULE_10] partner may drop data after strobe rises
// [RULE_11] reference clock follows system clock rate; the code toggles it every mclk, so it runs at half that rate
// [RULE_12] demultiplexed_mode: 24-bit address, 16-bit data lines
// [RULE_13] mux: address then data on shared lines
// [RULE_14] ready polarity selectable
// [RULE_15] async ready adds synchroniser, one wait
// [RULE_16] inactive ready waits, active ready ends cycle
// [RULE_17] partner drops ready before next sample
// [RULE_18] mux: address latch strobe during ab
// [RULE_19] chip select held from ab through f
// [RULE_20] byte high enable and split write strobes
`timescale 1ns/1ps
`include "ebc_cfg.svh"
module ebc_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external bus outputs
  output logic bus_reference_clock_out,
  output logic [23:0] address_lines,
  output logic [15:0] data_lines_out,
  output logic data_lines_oe,
  output logic [15:0] shared_address_data_lines_out,
  output logic shared_address_data_lines_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_lo_n,
  output logic wr_hi_n,
  output logic byte_high_enable_n,
  output logic [1:0] cs_n,
  // external bus inputs
  input wire logic [15:0] data_lines_in,
  input wire logic [15:0] shared_address_data_lines_in,
  input wire logic ready_in
);
  logic [31:0] ctrl;
  logic [13:0] timing [2];
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic busy;
  logic go;
  logic cmd_write, cmd_sel, cmd_hi, cmd_lo;
  logic [23:0] last_window;
  ebc_pkg::phase_t phase;
  logic [5:0] cnt;
  logic [13:0] tcfg;
  logic rdy_meta_q, rdy_sync, rdy_sync2;
  logic rdy_sample, rdy_active;
  logic [15:0] din;
  logic [31:0] din_q1, din_q2;

  // pick the config of the chip select in use
  assign tcfg = timing[cmd_sel]; // RULE_02
  assign rdy_sample = ctrl[`EBC_CTRL_RDY_ASYNC_BIT] ? rdy_sync2 : rdy_sync; // RULE_15
  assign rdy_active = rdy_sample ~^ ctrl[`EBC_CTRL_RDY_POL_BIT]; // RULE_14

  // ready: two stages for any pin, a third when used asynchronously
  ebc_sync u_rdy_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(ready_in),
    .q(rdy_sync)
  );
  assign rdy_meta_q = rdy_sync;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_sync2 <= 1'b0;
    end else begin
      rdy_sync2 <= rdy_meta_q; // RULE_15
    end
  end

  // both data buses pass two flops before the mode select may look at them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      din_q1 <= 32'h0000_0000;
      din_q2 <= 32'h0000_0000;
    end else begin
      din_q1 <= {shared_address_data_lines_in, data_lines_in};
      din_q2 <= din_q1;
    end
  end
  assign din = ctrl[`EBC_CTRL_MUX_BIT] ? din_q2[31:16] : din_q2[15:0];

  // reference clock: toggles at mclk rate, one period per two system periods
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_reference_clock_out <= 1'b0;
    end else begin
      bus_reference_clock_out <= ~bus_reference_clock_out; // RULE_11
    end
  end

  // bus slave: low one cycle after the request; cmd writes stall while a cycle runs
  // registered so the pin stays glitch free; high while idle, which the bus allows
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !(go || (busy &&
                         avs_write && avs_address[5:2] == `EBC_REG_CMD)));
    end
  end

  // configuration and command registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `EBC_CTRL_RESET;
      timing[0] <= `EBC_TIMING_RESET;
      timing[1] <= `EBC_TIMING_RESET;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      go <= 1'b0;
      cmd_write <= 1'b0;
      cmd_sel <= 1'b0;
      cmd_hi <= 1'b0;
      cmd_lo <= 1'b0;
    end else begin
      go <= 1'b0;
      if (avs_write && !avs_waitrequest) begin
        unique case (avs_address[5:2])
          `EBC_REG_CTRL: ctrl <= {28'h0000000, avs_writedata[3:0]};
          `EBC_REG_TIMING0: timing[0] <= avs_writedata[13:0];
          `EBC_REG_TIMING1: timing[1] <= avs_writedata[13:0];
          `EBC_REG_ADDR: addr_reg <= avs_writedata[23:0];
          `EBC_REG_WDATA: wdata_reg <= avs_writedata[15:0];
          `EBC_REG_CMD: begin
            // bit0 write, bit1 select, bit2 low byte, bit3 high byte
            go <= 1'b1;
            cmd_write <= avs_writedata[0];
            cmd_sel <= avs_writedata[1];
            cmd_lo <= avs_writedata[2];
            cmd_hi <= avs_writedata[3];
          end
          default: ;
        endcase
      end
    end
  end

  // register read mux
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read) begin
      unique case (avs_address[5:2])
        `EBC_REG_CTRL: avs_readdata <= ctrl;
        `EBC_REG_TIMING0: avs_readdata <= {18'h00000, timing[0]};
        `EBC_REG_TIMING1: avs_readdata <= {18'h00000, timing[1]};
        `EBC_REG_ADDR: avs_readdata <= {8'h00, addr_reg};
        `EBC_REG_WDATA: avs_readdata <= {16'h0000, wdata_reg};
        `EBC_REG_STATUS: avs_readdata <= {28'h0000000, 1'b0, phase};
        `EBC_REG_RDATA: avs_readdata <= {16'h0000, rdata_reg};
        default: avs_readdata <= `EBC_UNMAPPED_READ;
      endcase
    end
  end

  // phase sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= ebc_pkg::ST_IDLE;
      cnt <= 6'h00;
      busy <= 1'b0;
      last_window <= 24'h000000;
    end else begin
      unique case (phase)
        ebc_pkg::ST_IDLE: begin
          if (go) begin
            busy <= 1'b1;
            phase <= ebc_pkg::ST_AB; // RULE_01
            last_window <= {addr_reg[23:16], 15'h0000, cmd_sel};
            // 1-2 base steps, plus 0-3 when the window moves
            cnt <= {4'h0, tcfg[1:0] == 2'h0 ? 2'h1 : (tcfg[1:0] > 2'h2 ? 2'h2 : tcfg[1:0])}
                   + ((last_window != {addr_reg[23:16], 15'h0000, cmd_sel}) ?
                      {4'h0, tcfg[3:2]} : 6'h00); // RULE_04 RULE_03
          end
        end
        ebc_pkg::ST_AB: begin
          if (cnt > 6'h01) cnt <= cnt - 6'h01;
          else if (tcfg[5:4] != 2'h0) begin
            phase <= ebc_pkg::ST_C;
            cnt <= {4'h0, tcfg[5:4]}; // RULE_03
          end else if (tcfg[6] || ctrl[`EBC_CTRL_MUX_BIT]) begin
            phase <= ebc_pkg::ST_D;
            cnt <= 6'h01;
          end else begin
            phase <= ebc_pkg::ST_E;
            cnt <= {1'b0, tcfg[11:7]} + 6'h01; // RULE_03
          end
        end
        ebc_pkg::ST_C: begin
          if (cnt > 6'h01) cnt <= cnt - 6'h01;
          else if (tcfg[6] || ctrl[`EBC_CTRL_MUX_BIT]) begin
            phase <= ebc_pkg::ST_D;
            cnt <= 6'h01;
          end else begin
            phase <= ebc_pkg::ST_E;
            cnt <= {1'b0, tcfg[11:7]} + 6'h01;
          end
        end
        ebc_pkg::ST_D: begin
          phase <= ebc_pkg::ST_E; // RULE_05
          cnt <= {1'b0, tcfg[11:7]} + 6'h01;
        end
        ebc_pkg::ST_E: begin
          if (cnt > 6'h01) cnt <= cnt - 6'h01;
          else if (ctrl[`EBC_CTRL_RDY_EN_BIT] && !rdy_active) phase <= ebc_pkg::ST_RDY; // RULE_07
          else if (tcfg[13:12] != 2'h0) begin
            phase <= ebc_pkg::ST_F;
            cnt <= {4'h0, tcfg[13:12]};
          end else begin
            phase <= ebc_pkg::ST_IDLE;
            busy <= 1'b0;
          end
        end
        ebc_pkg::ST_RDY: begin
          // each inactive sample adds one wait state
          if (rdy_active) begin // RULE_16
            if (tcfg[13:12] != 2'h0) begin
              phase <= ebc_pkg::ST_F;
              cnt <= {4'h0, tcfg[13:12]};
            end else begin
              phase <= ebc_pkg::ST_IDLE;
              busy <= 1'b0;
            end
          end
        end
        ebc_pkg::ST_F: begin
          if (cnt > 6'h01) cnt <= cnt - 6'h01;
          else begin
            phase <= ebc_pkg::ST_IDLE; // RULE_06
            busy <= 1'b0;
          end
        end
        default: phase <= ebc_pkg::ST_IDLE;
      endcase
    end
  end

  // read data taken on the edge that ends the access phase; address change after
  // that edge cannot reach the captured word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
    end else if (!cmd_write && !rd_n && (phase == ebc_pkg::ST_E || phase == ebc_pkg::ST_RDY) &&
                 !(phase == ebc_pkg::ST_E && cnt > 6'h01) &&
                 (!ctrl[`EBC_CTRL_RDY_EN_BIT] || rdy_active)) begin
      rdata_reg <= din; // RULE_08 RULE_09 RULE_10
    end
  end

  // pin drivers, all registered from the next phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      address_lines <= 24'h000000;
      data_lines_out <= 16'h0000;
      data_lines_oe <= 1'b0;
      shared_address_data_lines_out <= 16'h0000;
      shared_address_data_lines_oe <= 1'b0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_lo_n <= 1'b1;
      wr_hi_n <= 1'b1;
      byte_high_enable_n <= 1'b1;
      cs_n <= 2'h3;
    end else begin
      if (phase == ebc_pkg::ST_IDLE && go) begin
        address_lines <= addr_reg; // RULE_12
        shared_address_data_lines_out <= addr_reg[15:0]; // RULE_13
        shared_address_data_lines_oe <= ctrl[`EBC_CTRL_MUX_BIT];
        ale <= ctrl[`EBC_CTRL_MUX_BIT]; // RULE_18
        cs_n <= cmd_sel ? 2'h1 : 2'h2; // RULE_19
        byte_high_enable_n <= !cmd_hi; // RULE_20
        data_lines_out <= wdata_reg;
        data_lines_oe <= cmd_write && !ctrl[`EBC_CTRL_MUX_BIT]; // RULE_12
      end else if (phase == ebc_pkg::ST_AB && cnt <= 6'h01) begin
        ale <= 1'b0;
        // mux: release lines for reads, switch to write data for writes
        shared_address_data_lines_oe <= ctrl[`EBC_CTRL_MUX_BIT] && cmd_write; // RULE_05
        shared_address_data_lines_out <= wdata_reg; // RULE_13
        if (tcfg[5:4] == 2'h0 && !tcfg[6] && !ctrl[`EBC_CTRL_MUX_BIT]) begin
          rd_n <= cmd_write;
          wr_lo_n <= !(cmd_write && cmd_lo); // RULE_20
          wr_hi_n <= !(cmd_write && cmd_hi);
        end
      end else if ((phase == ebc_pkg::ST_C && cnt <= 6'h01 && !tcfg[6] &&
                    !ctrl[`EBC_CTRL_MUX_BIT]) || phase == ebc_pkg::ST_D) begin
        rd_n <= cmd_write;
        wr_lo_n <= !(cmd_write && cmd_lo);
        wr_hi_n <= !(cmd_write && cmd_hi);
      end else if ((phase == ebc_pkg::ST_E && cnt <= 6'h01 &&
                    !(ctrl[`EBC_CTRL_RDY_EN_BIT] && !rdy_active)) ||
                   (phase == ebc_pkg::ST_RDY && rdy_active)) begin
        // command ends; address and write data stay for the hold phase
        rd_n <= 1'b1; // RULE_08
        wr_lo_n <= 1'b1;
        wr_hi_n <= 1'b1;
        if (tcfg[13:12] == 2'h0) begin
          cs_n <= 2'h3;
          data_lines_oe <= 1'b0;
          shared_address_data_lines_oe <= 1'b0;
          byte_high_enable_n <= 1'b1;
        end
      end else if (phase == ebc_pkg::ST_F && cnt <= 6'h01) begin
        cs_n <= 2'h3; // RULE_06 RULE_19
        data_lines_oe <= 1'b0;
        shared_address_data_lines_oe <= 1'b0;
        byte_high_enable_n <= 1'b1;
      end
    end
  end
endmodule

// [tb/ebc_sequencer_asserts.sv]
// checker for the external bus cycle sequencer pins
// assumes binding onto ebc_sequencer, one mclk domain
`timescale 1ns/1ps
module ebc_sequencer_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // external bus outputs
  input wire logic bus_reference_clock_out,
  input wire logic [23:0] address_lines,
  input wire logic data_lines_oe,
  input wire logic shared_address_data_lines_oe,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_lo_n,
  input wire logic wr_hi_n,
  input wire logic byte_high_enable_n,
  input wire logic [1:0] cs_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic stb;
  logic oe;
  // any strobe low, and any data drive
  assign stb = !rd_n || !wr_lo_n || !wr_hi_n;
  assign oe = data_lines_oe || shared_address_data_lines_oe;
  sequence clk_rise;
    $rose(bus_reference_clock_out);
  endsequence
  sequence rd_held;
    !rd_n ##1 !rd_n;
  endsequence
  a_ref_clock: assert property (clk_rise |=> !bus_reference_clock_out ##1 clk_rise)
    else $error("reference clock off rate");
  a_one_select: assert property (cs_n != 2'b00)
    else $error("two selects low");
  a_strobe_select: assert property (stb |-> cs_n != 2'b11)
    else $error("strobe without select");
  a_rd_wr_excl: assert property (!rd_n |-> wr_lo_n && wr_hi_n)
    else $error("read and write strobes together");
  a_ale_addr: assert property (ale |-> !stb && shared_address_data_lines_oe)
    else $error("latch strobe outside address setup");
  a_read_released: assert property (!rd_n |-> !oe)
    else $error("data driven during read");
  a_write_driven: assert property ($rose(wr_lo_n) && cs_n != 2'b11 |-> oe)
    else $error("write data dropped in hold");
  a_addr_stable: assert property (rd_held |-> $stable(address_lines))
    else $error("address moved during read");
  a_bhe_high: assert property (!wr_hi_n |-> !byte_high_enable_n)
    else $error("high write without byte enable");
  a_strobe_bound: assert property ($rose(stb) |-> ##[1:300] !stb)
    else $error("strobe never ends");
endmodule
bind ebc_sequencer ebc_sequencer_asserts chk (.mclk, .arst_n, .bus_reference_clock_out,
  .address_lines, .data_lines_oe, .shared_address_data_lines_oe, .ale, .rd_n, .wr_lo_n,
  .wr_hi_n, .byte_high_enable_n, .cs_n);

// [tb/ebc_ext_model.sv]
// external memory model: answers reads, drives ready on its own clock
// assumes the sequencer pins; mux says whether the answer uses the latched address
`timescale 1ns/1ps
module ebc_ext_model (
  // strobes and outputs of the sequencer
  input wire logic rd_n,
  input wire logic wr_lo_n,
  input wire logic wr_hi_n,
  input wire logic ale,
  input wire logic [23:0] address_lines,
  input wire logic [15:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic [15:0] shared_address_data_lines_out,
  input wire logic shared_address_data_lines_oe,
  // bench controls
  input wire logic multiplexed_mode,
  input wire logic rdy_pol,
  // answers
  output logic [15:0] data_lines_in,
  output logic [15:0] shared_address_data_lines_in,
  output logic ready_in
);
  logic lclk = 1'b0;
  logic [15:0] lat = 16'h0000;
  logic [15:0] val = 16'h0000;
  int cnt = 0;
  wire stb = !rd_n || !wr_lo_n || !wr_hi_n;
  initial forever #40 lclk = ~lclk;
  // address latch, as an external latch would hold it
  always @* if (ale) lat = shared_address_data_lines_out;
  // data is inverted once released so stale values never pass
  always @(negedge rd_n or posedge rd_n) val <= rd_n ? ~val : (multiplexed_mode ? lat : address_lines[15:0]) ^ 16'h5A5A;
  // wires resolve to whoever drives them
  assign data_lines_in = data_lines_oe ? data_lines_out : val;
  assign shared_address_data_lines_in = shared_address_data_lines_oe ? shared_address_data_lines_out : val;
  // slow answer: two link clocks, withdrawn as soon as the strobe rises
  always @(posedge lclk or negedge stb) if (!stb) cnt <= 0; else if (cnt < 3) cnt <= cnt + 1;
  assign ready_in = (cnt >= 2) ? rdy_pol : !rdy_pol;
endmodule

// [tb/tb_top.sv]
// self-checking bench: register tasks and bus cycle scenarios
// assumes the sequencer, its checker and the external device model
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, ready_in, rdy_pol, multiplexed_mode, cs_was;
  logic bus_reference_clock_out, data_lines_oe, shared_address_data_lines_oe, ale;
  logic rd_n, wr_lo_n, wr_hi_n, byte_high_enable_n;
  logic [1:0] cs_n, cs_snap;
  logic [3:0] avs_byteenable;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [23:0] address_lines, a_snap;
  logic [15:0] data_lines_out, shared_address_data_lines_out, data_lines_in, d_snap, ale_snap;
  logic [15:0] shared_address_data_lines_in;
  int error_cnt = 0, total_checks = 0, done_cnt = 0, cyc = 0;
  int pre, acc, post, hi_seen, bhe_seen;
  ebc_sequencer dut (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_reference_clock_out,
    .address_lines, .data_lines_out, .data_lines_oe, .shared_address_data_lines_out,
    .shared_address_data_lines_oe, .ale, .rd_n, .wr_lo_n, .wr_hi_n, .byte_high_enable_n,
    .cs_n, .data_lines_in, .shared_address_data_lines_in, .ready_in);
  ebc_ext_model ext (.rd_n, .wr_lo_n, .wr_hi_n, .ale, .address_lines, .data_lines_out,
    .data_lines_oe, .shared_address_data_lines_out, .shared_address_data_lines_oe, .multiplexed_mode,
    .rdy_pol, .data_lines_in, .shared_address_data_lines_in, .ready_in);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // phase counter: select low before, during and after the strobe
  always @(posedge mclk) begin
    if (cs_n != 2'b11) begin
      if (!(rd_n && wr_lo_n && wr_hi_n)) begin
        if (acc == 0) begin
          a_snap = address_lines;
          cs_snap = cs_n;
          d_snap = shared_address_data_lines_oe ? shared_address_data_lines_out : data_lines_out;
        end
        acc++;
      end else if (acc == 0) pre++;
      else post++;
      if (ale) ale_snap = shared_address_data_lines_out;
      if (!wr_hi_n) hi_seen = 1;
      if (!byte_high_enable_n) bhe_seen = 1;
    end else if (cs_was) done_cnt++;
    cs_was = (cs_n != 2'b11);
  end
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // one external bus cycle, then fetch the captured read data
  task automatic run(input logic [23:0] a, input logic [3:0] c);
    int n;
    n = done_cnt;
    bus(1'b1, 4'h3, {8'h00, a});
    pre = 0;
    acc = 0;
    post = 0;
    hi_seen = 0;
    bhe_seen = 0;
    bus(1'b1, 4'h5, {28'h0, c});
    for (int k = 0; k < 400 && done_cnt == n; k++) @(posedge mclk);
    `CHK(done_cnt, n + 1)
    bus(1'b0, 4'h7, 32'h0);
  endtask
  function automatic logic [31:0] tw(int ab, int x, int c, int d, int e, int f);
    return 32'((f << 12) | ((e - 1) << 7) | (d << 6) | (c << 4) | (x << 2) | ab);
  endfunction
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    rdy_pol = 1'b0;
    multiplexed_mode = 1'b0;
    cs_was = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 4'h1, 32'h0);
    `CHK(q, 32'h0000_0F81)
    bus(1'b1, 4'h9, 32'hFFFF_FFFF);
    bus(1'b0, 4'h9, 32'h0);
    `CHK(q, 32'h0000_0000)
    bus(1'b1, 4'h1, tw(1, 2, 1, 1, 4, 2));
    bus(1'b1, 4'h4, 32'h0000_A5C3);
    run(24'h12_3456, 4'hD);
    `CHK(a_snap, 24'h12_3456)
    `CHK(d_snap, 16'hA5C3)
    `CHK(acc, 4)
    `CHK(post, 2)
    `CHK(hi_seen, 1)
    `CHK(cs_snap, 2'b10)
    bus(1'b1, 4'h1, tw(1, 2, 1, 0, 4, 2));
    run(24'h12_7777, 4'hC);
    `CHK(pre, 2)
    `CHK(q, 32'h0000_2D2D)
    run(24'h34_1111, 4'hC);
    `CHK(pre, 4)
    `CHK(q, 32'h0000_4B4B)
    bus(1'b1, 4'h2, tw(2, 0, 3, 0, 6, 1));
    run(24'h34_2222, 4'hE);
    `CHK(pre, 5)
    `CHK(acc, 6)
    `CHK(post, 1)
    `CHK(q, 32'h0000_7878)
    `CHK(cs_snap, 2'b01)
    multiplexed_mode <= 1'b1;
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h1, tw(1, 0, 0, 1, 4, 1));
    bus(1'b1, 4'h4, 32'h0000_00C3);
    run(24'h12_BEEF, 4'h5);
    `CHK(ale_snap, 16'hBEEF)
    `CHK(d_snap, 16'h00C3)
    `CHK(hi_seen + bhe_seen, 0)
    run(24'h12_0F0F, 4'hC);
    `CHK(q, 32'h0000_5555)
    `CHK(bhe_seen, 1)
    multiplexed_mode <= 1'b0;
    bus(1'b1, 4'h1, tw(1, 0, 0, 0, 1, 0));
    // both ready polarities, synchronous then asynchronous sampling
    for (int p = 0; p < 4; p++) begin
      rdy_pol <= p[0];
      bus(1'b1, 4'h0, 32'h2 | (p << 2));
      run(24'h12_1234, 4'hC);
      `CHK(acc > 4, 1'b1)
      `CHK(q, 32'h0000_486E)
    end
    bus(1'b0, 4'h6, 32'h0);
    `CHK(q[2:0], ebc_pkg::ST_IDLE)
    print_verdict();
  end
endmodule
